// *** hw/lcfs_supervisor.sv ***
`timescale 1ns/1ps
`default_nettype none
module lcfs_supervisor
  import lcfs_pkg::*;
(
  input wire logic clock,              // 40 MHz clock
  input wire logic rst_n,              // power-on reset, active low
  input wire lcfs_sense_t senseIn,     // raw comparator and pin levels
  output lcfs_drive_t driveOut,        // driver controls
  output lcfs_flags_t flagsOut,        // current fault flags
  input wire logic faultIn,            // fault line level, high is idle
  output logic faultOut,               // fault line output value (always 0)
  output logic faultOe                 // pulldown active while high
);
  typedef enum {
    ST_SLEEP,
    ST_START,
    ST_RUN,
    ST_OPEN,
    ST_SHORT,
    ST_HOT
  } lcfs_state_t;

  // two-flop synchroniser for every asynchronous level
  lcfs_sense_t meta_r;
  lcfs_sense_t sync_r;
  logic faultMeta_r;
  logic faultSync_r;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      sync_r <= '0;
      faultMeta_r <= 1'b1;
      faultSync_r <= 1'b1;
    end else begin
      meta_r <= senseIn;
      sync_r <= meta_r;
      faultMeta_r <= faultIn;
      faultSync_r <= faultMeta_r;
    end
  end

  lcfs_state_t state_r;
  lcfs_state_t state_nxt;
  logic dimOut_r;
  logic dimOut_nxt;
  logic [CNT_W-1:0] dimCnt_r;
  logic [CNT_W-1:0] dimCnt_nxt;
  logic [CNT_W-1:0] startCnt_r;
  logic [CNT_W-1:0] startCnt_nxt;
  logic [CNT_W-1:0] recCnt_r;
  logic [CNT_W-1:0] recCnt_nxt;
  logic faultOe_r;
  lcfs_drive_t drive_r;
  lcfs_drive_t drive_nxt;
  lcfs_flags_t flags_r;
  lcfs_flags_t flags_nxt;

  // named decode of synchronised levels
  wire enabled = sync_r.enable;
  wire dimRaw = sync_r.dim;
  wire busLow = !faultSync_r || sync_r.busLow;
  wire ownFault = (state_r == ST_OPEN) || (state_r == ST_SHORT) || (state_r == ST_HOT);
  wire othersLow = busLow && !faultOe_r;
  wire channelOn = (state_r == ST_RUN) && !busLow;

  // delayed dim: output follows edges after fixed delays
  wire dimDiffers = (dimRaw != dimOut_r);
  wire [CNT_W-1:0] dimTarget = dimRaw ? CNT_W'(DIM_RISE_CYC - 1) : CNT_W'(DIM_FALL_CYC - 1);
  wire dimFire = dimDiffers && (dimCnt_r == dimTarget);
  assign dimOut_nxt = dimFire ? dimRaw : dimOut_r;
  assign dimCnt_nxt = (!dimDiffers || dimFire) ? CNT_ZERO : dimCnt_r + 13'h0001;

  // open and short diagnostics run only with channel on and dim high
  wire diagRun = channelOn && dimOut_r;
  wire openRun = diagRun && sync_r.openGate;
  wire openDone;
  wire shortDone;
  wire hotDone;

  // open qualification; drop above recovery restarts it
  lcfs_qual #(.LIMIT(OPEN_DEG_CYC)) openQual (
    .clock(clock),
    .rst_n(rst_n),
    .run(openRun),
    .cond(sync_r.dropLow),
    .cancel(sync_r.dropHigh),
    .done(openDone)
  );

  // short qualification; output above recovery resets it
  lcfs_qual #(.LIMIT(SHORT_DEG_CYC)) shortQual (
    .clock(clock),
    .rst_n(rst_n),
    .run(diagRun),
    .cond(sync_r.outLow),
    .cancel(sync_r.outHigh),
    .done(shortDone)
  );

  // thermal deglitch, active whenever enabled outside ST_HOT
  lcfs_qual #(.LIMIT(THERM_DEG_CYC)) hotQual (
    .clock(clock),
    .rst_n(rst_n),
    .run(enabled && state_r != ST_HOT),
    .cond(sync_r.hot),
    .cancel(1'b0),
    .done(hotDone)
  );

  // startup wait before current is driven
  wire startDone = (startCnt_r == CNT_W'(STARTUP_CYC - 1));
  assign startCnt_nxt = (state_r == ST_START && !startDone) ? startCnt_r + 13'h0001 : CNT_ZERO;

  // recovery deglitch for open and short retry
  wire openClear = sync_r.dropHigh;
  wire shortClear = sync_r.outHigh;
  wire recCond = (state_r == ST_OPEN && openClear) || (state_r == ST_SHORT && shortClear);
  wire recDone = (recCnt_r == CNT_W'(RECOVER_CYC - 1));
  assign recCnt_nxt = (recCond && !recDone) ? recCnt_r + 13'h0001 : CNT_ZERO;

  // channel state machine
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_SLEEP: begin
        if (enabled) begin
          state_nxt = ST_START;
        end
      end
      ST_START: begin
        if (!enabled) begin
          state_nxt = ST_SLEEP;
        end else if (hotDone) begin
          state_nxt = ST_HOT;
        end else if (startDone) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!enabled) begin
          state_nxt = ST_SLEEP;
        end else if (hotDone) begin
          state_nxt = ST_HOT;
        end else if (shortDone) begin
          state_nxt = ST_SHORT;
        end else if (openDone) begin
          state_nxt = ST_OPEN;
        end
      end
      ST_OPEN: begin
        if (!enabled) begin
          state_nxt = ST_SLEEP;
        end else if (hotDone) begin
          state_nxt = ST_HOT;
        end else if (recDone || !sync_r.openGate) begin
          state_nxt = ST_RUN;
        end
      end
      ST_SHORT: begin
        if (!enabled) begin
          state_nxt = ST_SLEEP;
        end else if (hotDone) begin
          state_nxt = ST_HOT;
        end else if (recDone) begin
          state_nxt = ST_RUN;
        end
      end
      ST_HOT: begin
        if (!enabled) begin
          state_nxt = ST_SLEEP;
        end else if (sync_r.cool) begin
          state_nxt = ST_RUN;
        end
      end
      default: state_nxt = ST_SLEEP;
    endcase
  end

  // driver controls per state
  always_comb begin
    drive_nxt = '0;
    case (state_nxt)
      ST_SLEEP: drive_nxt.sleep = 1'b1;
      ST_RUN: drive_nxt.driveOn = dimOut_nxt && !busLow;
      ST_OPEN: begin
        drive_nxt.driveOn = dimOut_nxt && !othersLow;
        drive_nxt.retryOn = !dimOut_nxt || othersLow;
      end
      ST_SHORT: drive_nxt.retryOn = 1'b1;
      default: drive_nxt = '0;
    endcase
    drive_nxt.faultMode = othersLow && enabled;
  end

  // fault flags follow state
  always_comb begin
    flags_nxt.open = (state_nxt == ST_OPEN);
    flags_nxt.shortGnd = (state_nxt == ST_SHORT);
    flags_nxt.thermal = (state_nxt == ST_HOT);
  end

  // state and output registers; rst_n is the power-on reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_SLEEP;
      dimOut_r <= 1'b0;
      dimCnt_r <= CNT_ZERO;
      startCnt_r <= CNT_ZERO;
      recCnt_r <= CNT_ZERO;
      faultOe_r <= 1'b0;
      drive_r <= 4'h2;
      flags_r <= '0;
    end else begin
      state_r <= state_nxt;
      dimOut_r <= dimOut_nxt;
      dimCnt_r <= dimCnt_nxt;
      startCnt_r <= startCnt_nxt;
      recCnt_r <= recCnt_nxt;
      faultOe_r <= (state_nxt == ST_OPEN) || (state_nxt == ST_SHORT) || (state_nxt == ST_HOT);
      drive_r <= drive_nxt;
      flags_r <= flags_nxt;
    end
  end

  // fault line is open-drain: drive low only; a strong pullup outside overpowers it
  assign faultOut = 1'b0;
  assign faultOe = faultOe_r;
  assign driveOut = drive_r;
  assign flagsOut = flags_r;
  wire unusedOwn = ownFault;
endmodule
`default_nettype wire

// *** hw/lcfs_pkg.sv ***
package lcfs_pkg;
  // clock rate in kilohertz
  localparam int CLK_KHZ = 40000;
  // documented times in microseconds
  localparam int THERM_DEG_US = 60;
  localparam int OPEN_DEG_US = 125;
  localparam int SHORT_DEG_US = 125;
  localparam int STARTUP_US = 100;
  localparam int DIM_RISE_US = 17;
  localparam int DIM_FALL_US = 21;
  localparam int RECOVER_US = 16;
  // cycle counts derived from the rate (nominal figures, exact at 40 MHz)
  localparam int THERM_DEG_CYC = THERM_DEG_US * CLK_KHZ / 1000;
  localparam int OPEN_DEG_CYC = OPEN_DEG_US * CLK_KHZ / 1000;
  localparam int SHORT_DEG_CYC = SHORT_DEG_US * CLK_KHZ / 1000;
  localparam int STARTUP_CYC = STARTUP_US * CLK_KHZ / 1000;
  localparam int DIM_RISE_CYC = DIM_RISE_US * CLK_KHZ / 1000;
  localparam int DIM_FALL_CYC = DIM_FALL_US * CLK_KHZ / 1000;
  localparam int RECOVER_CYC = RECOVER_US * CLK_KHZ / 1000;
  localparam int CNT_W = 13;
  localparam logic [CNT_W-1:0] CNT_ZERO = 13'h0000;

  // comparator and pin levels from the analog side
  typedef struct packed {
    logic enable;      // channel enable pin
    logic dim;         // dimming input
    logic openGate;    // open_check_gate, high enables open check
    logic dropLow;     // sense-to-output drop below open threshold
    logic dropHigh;    // drop above open-recovery threshold
    logic outLow;      // output below short threshold
    logic outHigh;     // output above short-recovery threshold
    logic hot;         // over thermal_trip point
    logic cool;        // below trip point minus hysteresis
    logic busLow;      // shared fault line reads low
  } lcfs_sense_t;

  // controls toward the analog driver
  typedef struct packed {
    logic driveOn;     // full regulated current
    logic retryOn;     // small retry current
    logic sleep;       // sleep, minimal activity
    logic faultMode;   // low-current fault mode
  } lcfs_drive_t;

  typedef struct packed {
    logic open;
    logic shortGnd;
    logic thermal;
  } lcfs_flags_t;
endpackage

// *** hw/lcfs_qual.sv ***
`timescale 1ns/1ps
`default_nettype none
// persistence timer: counts while cond holds, restarts on cancel or when idle
module lcfs_qual
  import lcfs_pkg::*;
#(
  parameter int LIMIT = 1
) (
  input wire logic clock,              // system clock
  input wire logic rst_n,              // async reset, active low
  input wire logic run,                // qualification allowed
  input wire logic cond,               // condition present
  input wire logic cancel,             // recovery level seen, restart
  output logic done                    // condition persisted LIMIT cycles
);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(LIMIT - 1);
  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] count_nxt;
  logic done_r;
  wire counting = run && cond && !cancel;
  wire atLast = (count_r == LAST);

  assign count_nxt = !counting ? CNT_ZERO : (atLast ? count_r : count_r + 13'h0001);
  assign done = done_r;

  // counter and sticky-while-held done
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= CNT_ZERO;
      done_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      done_r <= counting && atLast;
    end
  end
endmodule
`default_nettype wire

// *** tb/lcfs_bus_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// shared fault line with its weak pullup, other drivers and an optional strong pullup
module lcfs_bus_model (
  input wire logic faultOe,   // device pulldown active
  input wire logic othersLow, // another driver pulls the line low
  input wire logic strongUp,  // outside pullup stronger than any pulldown
  output logic faultIn        // resolved line level
);
  // weak pullup idles high, a strong pullup overrides every pulldown
  assign faultIn = strongUp | ~(faultOe | othersLow);
endmodule
`default_nettype wire

// *** tb/lcfs_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module lcfs_checker
  import lcfs_pkg::*;
(
  input wire logic clock,           // system clock
  input wire logic rst_n,           // reset, active low
  input wire lcfs_sense_t senseIn,  // raw levels
  input wire lcfs_drive_t driveOut, // driver controls
  input wire lcfs_flags_t flagsOut, // fault flags
  input wire logic faultIn,         // line level
  input wire logic faultOut,        // line value
  input wire logic faultOe          // pulldown enable
);
  logic [12:0] lowCnt_r, dropCnt_r, hotCnt_r, enCnt_r;
  // saturating run length of a level
  function automatic logic [12:0] runLen(logic [12:0] c, logic lvl);
    return lvl ? ((c == 13'h1fff) ? c : c + 13'h0001) : 13'h0000;
  endfunction
  // how long each checked raw level (outLow, dropLow, hot, enable) has been held
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lowCnt_r <= 13'h0000;
      dropCnt_r <= 13'h0000;
      hotCnt_r <= 13'h0000;
      enCnt_r <= 13'h0000;
    end else begin
      lowCnt_r <= runLen(lowCnt_r, senseIn.outLow);
      dropCnt_r <= runLen(dropCnt_r, senseIn.dropLow);
      hotCnt_r <= runLen(hotCnt_r, senseIn.hot);
      enCnt_r <= runLen(enCnt_r, senseIn.enable);
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_oe_on_fault: assert property ($rose(|flagsOut) |-> ##[0:3] faultOe)
    else $error("pulldown missing after fault");
  a_out_zero: assert property (faultOut == 1'b0)
    else $error("fault line value not low");
  a_oe_release: assert property ($fell(|flagsOut) |-> ##[0:3] !faultOe)
    else $error("pulldown held after fault cleared");
  a_sleep_enable: assert property ((!senseIn.enable)[*5] |=> driveOut.sleep)
    else $error("no sleep with enable low");
  a_short_off: assert property ($rose(flagsOut.shortGnd) |-> ##[0:2]
    (!driveOut.driveOn && driveOut.retryOn))
    else $error("short fault without retry current");
  a_thermal_off: assert property ($rose(flagsOut.thermal) |-> ##[0:2]
    (!driveOut.driveOn && !driveOut.retryOn))
    else $error("output on during thermal trip");
  a_bus_off: assert property ((!faultIn && !faultOe)[*4] |=> !driveOut.driveOn)
    else $error("driver on with line pulled low");
  a_short_qual: assert property ($rose(flagsOut.shortGnd) |-> lowCnt_r >= SHORT_DEG_CYC - 8)
    else $error("short flagged too early");
  a_open_qual: assert property ($rose(flagsOut.open) |-> dropCnt_r >= OPEN_DEG_CYC - 8)
    else $error("open flagged too early");
  a_therm_qual: assert property ($rose(flagsOut.thermal) |-> hotCnt_r >= THERM_DEG_CYC - 8)
    else $error("thermal flagged too early");
  a_start_delay: assert property ($rose(driveOut.driveOn) |-> enCnt_r >= STARTUP_CYC - 8)
    else $error("output on too soon after enable");
endmodule
bind lcfs_supervisor lcfs_checker chk (.clock(clock), .rst_n(rst_n), .senseIn(senseIn),
  .driveOut(driveOut), .flagsOut(flagsOut), .faultIn(faultIn), .faultOut(faultOut),
  .faultOe(faultOe));
`default_nettype wire

// *** tb/lcfs_supervisor_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module lcfs_supervisor_tb_top
  import lcfs_pkg::*;
;
  logic clock, rst_n, othersLow, strongUp, faultIn, faultOut, faultOe;
  lcfs_sense_t senseIn;
  lcfs_drive_t d;
  lcfs_flags_t f;
  int bad_count, total_checks;
  lcfs_supervisor dut (.clock(clock), .rst_n(rst_n), .senseIn(senseIn), .driveOut(d),
    .flagsOut(f), .faultIn(faultIn), .faultOut(faultOut), .faultOe(faultOe));
  lcfs_bus_model bus (.faultOe(faultOe), .othersLow(othersLow), .strongUp(strongUp),
    .faultIn(faultIn));
  // 40 MHz clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task automatic cyc(int n);
    repeat (n) @(posedge clock);
    #2;
  endtask
  task automatic chk(string what, logic [3:0] seen, logic [3:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic t_reset();
    chk("drive in reset", d, 4'h2);
    chk("flags in reset", {1'b0, f}, 4'h0);
    chk("line value", {3'h0, faultOut}, 4'h0);
    rst_n = 1'b1;
    cyc(10);
    chk("drive asleep", d, 4'h2);
  endtask
  task automatic t_start();
    senseIn.dim = 1'b1;
    senseIn.enable = 1'b1;
    cyc(STARTUP_CYC - 10);
    chk("drive early", d, 4'h0);
    cyc(100);
    chk("drive started", d, 4'h8);
  endtask
  task automatic t_dim();
    senseIn.dim = 1'b0;
    cyc(DIM_FALL_CYC - 10);
    chk("dim fall early", {3'h0, d.driveOn}, 4'h1);
    cyc(30);
    chk("dim fall", {3'h0, d.driveOn}, 4'h0);
    senseIn.outLow = 1'b1;
    senseIn.outHigh = 1'b0;
    cyc(SHORT_DEG_CYC + 50);
    chk("flags dim low", {1'b0, f}, 4'h0);
    senseIn.outLow = 1'b0;
    senseIn.outHigh = 1'b1;
    senseIn.dim = 1'b1;
    cyc(DIM_RISE_CYC - 10);
    chk("dim rise early", {3'h0, d.driveOn}, 4'h0);
    cyc(30);
    chk("dim rise", {3'h0, d.driveOn}, 4'h1);
  endtask
  task automatic t_short();
    senseIn.outLow = 1'b1;
    senseIn.outHigh = 1'b0;
    cyc(3000);
    senseIn.outLow = 1'b0;
    senseIn.outHigh = 1'b1;
    cyc(5);
    senseIn.outLow = 1'b1;
    senseIn.outHigh = 1'b0;
    cyc(SHORT_DEG_CYC - 10);
    chk("short restarted", {1'b0, f}, 4'h0);
    cyc(30);
    chk("short flag", {1'b0, f}, 4'h2);
    chk("short line", {3'h0, faultOe}, 4'h1);
    chk("short retry", {2'h0, d.driveOn, d.retryOn}, 4'h1);
    senseIn.outLow = 1'b0;
    senseIn.outHigh = 1'b1;
    cyc(RECOVER_CYC + 30);
    chk("short cleared", {f, faultOe}, 4'h0);
    chk("short resumed", {3'h0, d.driveOn}, 4'h1);
  endtask
  task automatic t_bus();
    othersLow = 1'b1;
    cyc(6);
    chk("bus low", {2'h0, d.driveOn, d.faultMode}, 4'h1);
    othersLow = 1'b0;
    cyc(10);
    chk("bus released", {3'h0, d.driveOn}, 4'h1);
  endtask
  task automatic t_therm();
    senseIn.hot = 1'b1;
    senseIn.cool = 1'b0;
    cyc(THERM_DEG_CYC - 10);
    chk("hot early", {1'b0, f}, 4'h0);
    cyc(30);
    chk("hot trip", {f, faultOe}, 4'h3);
    chk("hot drive", {2'h0, d.driveOn, d.retryOn}, 4'h0);
    senseIn.hot = 1'b0;
    cyc(300);
    chk("hot held", {1'b0, f}, 4'h1);
    senseIn.cool = 1'b1;
    cyc(700);
    chk("cooled", {f, d.driveOn}, 4'h1);
  endtask
  task automatic t_open();
    strongUp = 1'b1;
    senseIn.dropLow = 1'b1;
    senseIn.dropHigh = 1'b0;
    cyc(OPEN_DEG_CYC + 50);
    chk("open gated", {1'b0, f}, 4'h0);
    senseIn.openGate = 1'b1;
    cyc(OPEN_DEG_CYC - 10);
    chk("open early", {1'b0, f}, 4'h0);
    cyc(30);
    chk("open flag", {f, faultOe}, 4'h9);
    chk("open drive", {3'h0, d.driveOn}, 4'h1);
    senseIn.dim = 1'b0;
    cyc(DIM_FALL_CYC + 30);
    chk("open retry", {2'h0, d.driveOn, d.retryOn}, 4'h1);
    senseIn.dim = 1'b1;
    cyc(DIM_RISE_CYC + 30);
    senseIn.dropLow = 1'b0;
    senseIn.dropHigh = 1'b1;
    cyc(RECOVER_CYC + 30);
    chk("open cleared", {f, faultOe}, 4'h0);
  endtask
  task automatic t_sleep();
    senseIn.enable = 1'b0;
    cyc(10);
    chk("sleep", d, 4'h2);
  endtask
  // watchdog well beyond the planned run
  initial begin
    repeat (60000) @(posedge clock);
    bad_count++;
    give_verdict();
  end
  // main sequence
  initial begin
    bad_count = 0;
    total_checks = 0;
    rst_n = 1'b0;
    othersLow = 1'b0;
    strongUp = 1'b0;
    senseIn = '0;
    senseIn.dropHigh = 1'b1;
    senseIn.outHigh = 1'b1;
    senseIn.cool = 1'b1;
    cyc(6);
    t_reset();
    t_start();
    t_dim();
    t_short();
    t_bus();
    t_therm();
    t_open();
    t_sleep();
    give_verdict();
  end
endmodule
`default_nettype wire
